// ==== src/pad_attr_regs.sv ====
// Top module: pad attribute register bank for a 24-pin always-on port
// What this block does
// [RULE_01] Data bit n written only if bit n+16 set
// [RULE_02] Enable bit 31 gates data bit 15
// [RULE_03] Unenabled data bits keep their old value
// [RULE_04] Pull field: none, up, down, keeper
// [RULE_05] Drive field: 2, 4, 8, 12 mA
// [RULE_06] Slew bit: zero slow, one fast
// [RULE_07] Hysteresis bit enables Schmitt trigger input
// [RULE_08] Enable half and reserved bits read zero
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pad_attr_regs
  import pad_attr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [PADA_AW-1:0] reg_addr,
  input wire logic [PADA_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PADA_DW-1:0] reg_rdata,
  output logic [15:0] group_c_pull,
  output logic [15:0] group_a_drive,
  output logic [15:0] group_b_drive,
  output logic [15:0] group_c_drive,
  output logic [23:0] pin_slew_fast,
  output logic [15:0] pin_hysteresis
);
  pada_wr_if wr_bus();
  logic [PADA_HW-1:0] regv [PADA_NREG];

  // Address decode to a one-hot register select
  function automatic logic [PADA_NREG-1:0] pada_decode(
      input logic [PADA_AW-1:0] a);
    logic [PADA_NREG-1:0] s;
    s = '0;
    unique case (a)
      PADA_OFS_C_PULL: s[PADA_IX_C_PULL] = 1'b1;
      PADA_OFS_A_DRIVE: s[PADA_IX_A_DRIVE] = 1'b1;
      PADA_OFS_B_DRIVE: s[PADA_IX_B_DRIVE] = 1'b1;
      PADA_OFS_C_DRIVE: s[PADA_IX_C_DRIVE] = 1'b1;
      PADA_OFS_SLEW_LO: s[PADA_IX_SLEW_LO] = 1'b1;
      PADA_OFS_SLEW_HI: s[PADA_IX_SLEW_HI] = 1'b1;
      PADA_OFS_HYST_LO: s[PADA_IX_HYST_LO] = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  // Upper half carries the write enables, lower half the data
  assign wr_bus.sel = reg_wr ? pada_decode(reg_addr) : '0;
  assign wr_bus.data = reg_wdata[PADA_HW-1:0];
  assign wr_bus.bit_en = reg_wdata[PADA_DW-1:PADA_HW]; // [RULE_01] [RULE_02]

  pada_mreg #(.IDX(PADA_IX_C_PULL), .RESET_VAL(PADA_RST_C_PULL),
    .IMPL_MASK(PADA_MASK_FULL)) u_c_pull (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_C_PULL]));
  pada_mreg #(.IDX(PADA_IX_A_DRIVE), .RESET_VAL(PADA_RST_A_DRIVE),
    .IMPL_MASK(PADA_MASK_FULL)) u_a_drive (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_A_DRIVE]));
  pada_mreg #(.IDX(PADA_IX_B_DRIVE), .RESET_VAL(PADA_RST_ZERO),
    .IMPL_MASK(PADA_MASK_FULL)) u_b_drive (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_B_DRIVE]));
  pada_mreg #(.IDX(PADA_IX_C_DRIVE), .RESET_VAL(PADA_RST_ZERO),
    .IMPL_MASK(PADA_MASK_FULL)) u_c_drive (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_C_DRIVE]));
  pada_mreg #(.IDX(PADA_IX_SLEW_LO), .RESET_VAL(PADA_RST_ZERO),
    .IMPL_MASK(PADA_MASK_FULL)) u_slew_lo (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_SLEW_LO]));
  // Only group C lives here; upper byte is reserved
  pada_mreg #(.IDX(PADA_IX_SLEW_HI), .RESET_VAL(PADA_RST_ZERO),
    .IMPL_MASK(PADA_MASK_LOW8)) u_slew_hi (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_SLEW_HI]));
  pada_mreg #(.IDX(PADA_IX_HYST_LO), .RESET_VAL(PADA_RST_ZERO),
    .IMPL_MASK(PADA_MASK_FULL)) u_hyst_lo (.clk_sys(clk_sys),
    .resetn(resetn), .wr(wr_bus), .value(regv[PADA_IX_HYST_LO]));

  typedef struct packed {
    logic [PADA_DW-1:0] rdata;
    logic [15:0] c_pull;
    logic [15:0] a_drive;
    logic [15:0] b_drive;
    logic [15:0] c_drive;
    logic [23:0] slew;
    logic [15:0] hyst;
  } pada_top_st_t;
  pada_top_st_t st_reg;
  pada_top_st_t st_next;

  always_comb begin
    logic [PADA_NREG-1:0] rsel;
    rsel = pada_decode(reg_addr);
    st_next = st_reg;
    // Read data valid only in the cycle after the strobe
    st_next.rdata = '0;
    if (reg_rd) begin
      for (int i = 0; i < PADA_NREG; i++) begin
        if (rsel[i]) begin
          st_next.rdata = {{PADA_HW{1'b0}}, regv[i]}; // [RULE_08]
        end
      end
    end
    // Registered copies drive the pad cells glitch-free
    st_next.c_pull = regv[PADA_IX_C_PULL]; // [RULE_04]
    st_next.a_drive = regv[PADA_IX_A_DRIVE]; // [RULE_05]
    st_next.b_drive = regv[PADA_IX_B_DRIVE]; // [RULE_05]
    st_next.c_drive = regv[PADA_IX_C_DRIVE]; // [RULE_05]
    st_next.slew = {regv[PADA_IX_SLEW_HI][7:0],
                    regv[PADA_IX_SLEW_LO]}; // [RULE_06]
    st_next.hyst = regv[PADA_IX_HYST_LO]; // [RULE_07]
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{rdata: '0, c_pull: PADA_RST_C_PULL,
                  a_drive: PADA_RST_A_DRIVE, b_drive: PADA_RST_ZERO,
                  c_drive: PADA_RST_ZERO, slew: '0, hyst: PADA_RST_ZERO};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign group_c_pull = st_reg.c_pull;
  assign group_a_drive = st_reg.a_drive;
  assign group_b_drive = st_reg.b_drive;
  assign group_c_drive = st_reg.c_drive;
  assign pin_slew_fast = st_reg.slew;
  assign pin_hysteresis = st_reg.hyst;
endmodule // pad_attr_regs
`default_nettype wire

// ==== src/pad_attr_pkg.sv ====
// Package: register map, field layout and reset values of the pad attribute bank
package pad_attr_pkg;
  localparam int PADA_AW = 8;
  localparam int PADA_DW = 32;
  localparam int PADA_HW = 16;
  localparam int PADA_NREG = 7;
  // Register byte offsets
  localparam logic [PADA_AW-1:0] PADA_OFS_C_PULL = 8'h18;
  localparam logic [PADA_AW-1:0] PADA_OFS_A_DRIVE = 8'h20;
  localparam logic [PADA_AW-1:0] PADA_OFS_B_DRIVE = 8'h24;
  localparam logic [PADA_AW-1:0] PADA_OFS_C_DRIVE = 8'h28;
  localparam logic [PADA_AW-1:0] PADA_OFS_SLEW_LO = 8'h30;
  localparam logic [PADA_AW-1:0] PADA_OFS_SLEW_HI = 8'h34;
  localparam logic [PADA_AW-1:0] PADA_OFS_HYST_LO = 8'h38;
  // Register indices
  localparam int PADA_IX_C_PULL = 0;
  localparam int PADA_IX_A_DRIVE = 1;
  localparam int PADA_IX_B_DRIVE = 2;
  localparam int PADA_IX_C_DRIVE = 3;
  localparam int PADA_IX_SLEW_LO = 4;
  localparam int PADA_IX_SLEW_HI = 5;
  localparam int PADA_IX_HYST_LO = 6;
  // Reset values of the data half-words
  localparam logic [PADA_HW-1:0] PADA_RST_C_PULL = 16'h00AA;
  localparam logic [PADA_HW-1:0] PADA_RST_A_DRIVE = 16'h0001;
  localparam logic [PADA_HW-1:0] PADA_RST_ZERO = 16'h0000;
  // Implemented data bits per register; the rest read zero
  localparam logic [PADA_HW-1:0] PADA_MASK_FULL = 16'hFFFF;
  localparam logic [PADA_HW-1:0] PADA_MASK_LOW8 = 16'h00FF;
  // Pull field encodings
  typedef enum logic [1:0] {
    PADA_PULL_NONE = 2'b00,
    PADA_PULL_UP = 2'b01,
    PADA_PULL_DOWN = 2'b10,
    PADA_PULL_KEEP = 2'b11
  } pada_pull_t;
  // Drive strength encodings
  typedef enum logic [1:0] {
    PADA_DRV_2MA = 2'b00,
    PADA_DRV_4MA = 2'b01,
    PADA_DRV_8MA = 2'b10,
    PADA_DRV_12MA = 2'b11
  } pada_drive_t;
  localparam logic PADA_SLEW_SLOW = 1'b0;
  localparam logic PADA_SLEW_FAST = 1'b1;
  localparam logic PADA_HYST_OFF = 1'b0;
  localparam logic PADA_HYST_ON = 1'b1;
endpackage

// ==== src/pada_wr_if.sv ====
// Interface: decoded write carrying data and per-bit write enables
`timescale 1ns/1ps
`default_nettype none
interface pada_wr_if;
  import pad_attr_pkg::*;
  logic [PADA_NREG-1:0] sel;
  logic [PADA_HW-1:0] data;
  logic [PADA_HW-1:0] bit_en;
  modport src (output sel, output data, output bit_en);
  modport dst (input sel, input data, input bit_en);
endinterface
`default_nettype wire

// ==== src/pada_mreg.sv ====
// Module: one bit-masked pad attribute register
`timescale 1ns/1ps
`default_nettype none
module pada_mreg
  import pad_attr_pkg::*;
#(
  parameter int IDX = 0,
  parameter logic [PADA_HW-1:0] RESET_VAL = 16'h0000,
  parameter logic [PADA_HW-1:0] IMPL_MASK = 16'hFFFF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  pada_wr_if.dst wr,
  output logic [PADA_HW-1:0] value
);
  typedef struct packed {
    logic [PADA_HW-1:0] data;
  } pada_mreg_st_t;
  pada_mreg_st_t st_reg;
  pada_mreg_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr.sel[IDX]) begin
      // Each data bit n changes only with enable bit n+16 set
      st_next.data = ((st_reg.data & ~wr.bit_en) |
                      (wr.data & wr.bit_en)) & IMPL_MASK; // [RULE_01] [RULE_02] [RULE_03]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{data: RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.data;
endmodule // pada_mreg
`default_nettype wire

// ==== sim/pad_attr_regs_assertions.sv ====
// Checker: port-level behaviour of the pad attribute bank
`timescale 1ns/1ps
`default_nettype none
module pada_chk
  import pad_attr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [PADA_AW-1:0] reg_addr,
  input wire logic [PADA_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [PADA_DW-1:0] reg_rdata,
  input wire logic [15:0] group_c_pull,
  input wire logic [15:0] group_a_drive,
  input wire logic [23:0] pin_slew_fast,
  input wire logic [15:0] pin_hysteresis
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Quiet after the write so no later one overlaps
  sequence s_full(a);
    reg_wr && reg_addr == a && reg_wdata[31:16] == 16'hFFFF ##1 !reg_wr[*2];
  endsequence
  property p_upper; reg_rdata[31:16] == 16'h0000; endproperty
  property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  property p_resv;
    reg_rd && reg_addr == PADA_OFS_SLEW_HI |=> reg_rdata[15:8] == 8'h00;
  endproperty
  property p_unmap;
    reg_rd && !(reg_addr inside {8'h18, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34,
      8'h38}) |=> reg_rdata == 32'h0;
  endproperty
  property p_keep;
    !reg_wr[*2] ##1 (reg_wr && reg_addr == PADA_OFS_A_DRIVE &&
      reg_wdata[31:16] == 16'h0000) ##1 !reg_wr[*3]
      |-> group_a_drive == $past(group_a_drive, 3);
  endproperty
  property p_pull;
    s_full(PADA_OFS_C_PULL) |-> group_c_pull == $past(reg_wdata[15:0], 2);
  endproperty
  property p_slew;
    s_full(PADA_OFS_SLEW_HI) |-> pin_slew_fast[23:16] ==
      $past(reg_wdata[7:0], 2);
  endproperty
  property p_hyst;
    s_full(PADA_OFS_HYST_LO) |-> pin_hysteresis == $past(reg_wdata[15:0], 2);
  endproperty
  a_upper: assert property (p_upper) else $error("rdata upper");
  a_idle: assert property (p_idle) else $error("rdata idle");
  a_resv: assert property (p_resv) else $error("reserved bits");
  a_unmap: assert property (p_unmap) else $error("unmapped");
  a_keep: assert property (p_keep) else $error("no enable");
  a_pull: assert property (p_pull) else $error("pull");
  a_slew: assert property (p_slew) else $error("slew");
  a_hyst: assert property (p_hyst) else $error("hysteresis");
endmodule // pada_chk
bind pad_attr_regs pada_chk pada_chk_i (.clk_sys, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .group_c_pull, .group_a_drive,
  .pin_slew_fast, .pin_hysteresis);
`default_nettype wire

// ==== sim/pad_attr_regs_tb.sv ====
// Testbench: corner and random register traffic on the pad bank
`timescale 1ns/1ps
`default_nettype none
module pad_attr_regs_tb import pad_attr_pkg::*;;
  logic clk_sys = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r, seed = 32'h98FE9951;
  logic [15:0] group_c_pull, group_a_drive, group_b_drive, group_c_drive;
  logic [15:0] pin_hysteresis;
  logic [23:0] pin_slew_fast;
  // Slot 7 is an unmapped hole; its mask keeps the model at zero
  logic [7:0] ofs [8] = '{8'h18, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38,
    8'h2C};
  logic [15:0] mk [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'h00FF, 16'hFFFF, 16'h0000};
  logic [15:0] m [8] = '{16'h00AA, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0};
  int fails = 0, n_checks = 0;
  pad_attr_regs pad_attr_regs_i (.clk_sys, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .group_c_pull, .group_a_drive,
    .group_b_drive, .group_c_drive, .pin_slew_fast, .pin_hysteresis);
  initial forever #2.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] f_upd(input logic [15:0] o, d, e, k);
    return ((o & ~e) | (d & e)) & k;
  endfunction
  task automatic check(input string nm, input logic [127:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    reg_addr <= ofs[i];
    reg_wdata <= d;
    reg_wr <= 1'h1;
    m[i] = f_upd(m[i], d[15:0], d[31:16], mk[i]);
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
    #1;
    check("c_pull", group_c_pull, m[0]);
    check("a_drive", group_a_drive, m[1]);
    check("b_drive", group_b_drive, m[2]);
    check("c_drive", group_c_drive, m[3]);
    check("slew", pin_slew_fast, {m[5][7:0], m[4]});
    check("hyst", pin_hysteresis, m[6]);
    @(posedge clk_sys);
  endtask
  task automatic rd(input int i);
    reg_addr <= ofs[i];
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    check("rdata", reg_rdata, {16'h0000, m[i]});
    @(posedge clk_sys);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd(i);
    // Every pull and drive code, then a write with no enables
    for (int k = 0; k < 96; k++) begin
      r = xs();
      if (k < 8) wr(k, 32'hFFFFE4E4);
      else if (k < 16) wr(k - 8, 32'h00001B1B);
      else wr(r[2:0], xs());
      rd(k < 16 ? k % 8 : r[2:0]);
    end
    final_report();
  end
endmodule // pad_attr_regs_tb
`default_nettype wire
